// [pkg/fic_params.svh]
// Purpose: Constants for the conversion and conditional negate datapath.
// Assumes: Included by bare name wherever a constant is needed.
// Notes: Definitions only.
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH

// =====================================================================
// Operation codes
`define FIC_OPC_W 8
`define FIC_OPC_F2I_TRUNC 8'h15
`define FIC_OPC_F2I_TRUNC_FLAGS 8'h81
`define FIC_OPC_COND_NEGATE 8'h4d
`define FIC_OPC_I2F 8'h14

// =====================================================================
// Latencies in cycles from issue edge to write edge
`define FIC_FALU_LATENCY 3
`define FIC_DSP_LATENCY 2

// =====================================================================
// Status word layout
`define FIC_INEXACT_BIT 1
`define FIC_OVERFLOW_BIT 2
`define FIC_UNDERFLOW_BIT 3
`define FIC_BAD_OPERAND_BIT 4
`define FIC_DENORM_ZEROED_BIT 5
`define FIC_FLAG_MASK 32'h0000_003e
`define FIC_RMODE_LSB 8
`define FIC_RMODE_MSB 9
`define FIC_STATUS_RESET 32'h0000_0000

// =====================================================================
// Rounding mode encodings
`define FIC_RM_NEAREST 2'h0
`define FIC_RM_ZERO 2'h1
`define FIC_RM_POS 2'h2
`define FIC_RM_NEG 2'h3

// =====================================================================
// Float field limits
`define FIC_EXP_BIAS 8'h7f
`define FIC_EXP_SAT 8'h9e
`define FIC_EXP_SPECIAL 8'hff
`define FIC_INT_MAX 32'h7fff_ffff
`define FIC_INT_MIN 32'h8000_0000

`endif

// [pkg/fic_pkg.sv]
// Purpose: Shared types of the conversion datapath.
// Assumes: Constants live in fic_params.svh.
// Notes: Types only.
package fic_pkg;

  // ===================================================================
  // Types
  typedef enum logic [1:0] {
    FIC_OP_F2I,
    FIC_OP_F2I_FLAGS,
    FIC_OP_I2F
  } fic_op_t;

  typedef logic [31:0] fic_word_t;

endpackage

// [pkg/fic_cvt_if.sv]
// Purpose: Link between the pipeline control and the integer-to-float converter.
// Assumes: Operand and mode are sampled on every clock edge.
// Notes: Result and flags appear two edges after the operand.
interface fic_cvt_if;
  fic_pkg::fic_word_t operand;
  logic [1:0] rmode;
  fic_pkg::fic_word_t result;
  fic_pkg::fic_word_t flags;

  modport requester (
    output operand,
    output rmode,
    input result,
    input flags
  );

  modport converter (
    input operand,
    input rmode,
    output result,
    output flags
  );
endinterface

// [verilog/fic_int_to_float.sv]
// Purpose: Two-stage signed integer to single-precision conversion.
// Assumes: One new operand may enter on every clock edge.
// Notes: Result can never overflow, so only inexact is raised.
`include "fic_params.svh"

module fic_int_to_float (
  input wire logic ref_clk,
  input wire logic rst,
  fic_cvt_if.converter cvt
);

  // ===================================================================
  // Stage one: sign and magnitude
  logic a_sign;
  logic [31:0] a_mag;
  logic [1:0] a_rmode;
  wire [31:0] abs_in = cvt.operand[31] ? -cvt.operand : cvt.operand;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_sign <= 1'b0;
      a_mag <= 32'h0;
      a_rmode <= 2'h0;
    end else begin
      a_sign <= cvt.operand[31];
      a_mag <= abs_in;
      a_rmode <= cvt.rmode;
    end
  end

  // ===================================================================
  // Stage two: normalise and round
  logic [4:0] lead;
  always_comb begin
    lead = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (a_mag[i]) begin
        lead = 5'(i);
      end
    end
  end

  wire is_zero = (a_mag == 32'h0);
  wire [31:0] norm = a_mag << (5'h1f - lead);
  wire [22:0] mant = norm[30:8];
  wire rnd_bit = norm[7];
  wire sticky = |norm[6:0];
  wire lost = rnd_bit | sticky;
  wire round_up = (a_rmode == `FIC_RM_NEAREST) ? (rnd_bit & (sticky | mant[0])) :
                  (a_rmode == `FIC_RM_POS) ? (~a_sign & lost) :
                  (a_rmode == `FIC_RM_NEG) ? (a_sign & lost) : 1'b0;
  wire [23:0] mant_r = {1'b0, mant} + {23'h0, round_up};
  wire [7:0] exp_f = `FIC_EXP_BIAS + {3'h0, lead} + {7'h0, mant_r[23]};
  wire [31:0] next_result = is_zero ? 32'h0 : {a_sign, exp_f, mant_r[22:0]};
  wire [31:0] next_flags = {31'h0, ~is_zero & lost} << `FIC_INEXACT_BIT;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cvt.result <= 32'h0;
      cvt.flags <= 32'h0;
    end else begin
      cvt.result <= next_result;
      cvt.flags <= next_flags;
    end
  end

endmodule

// [verilog/fic_top.sv]
// Purpose: Float/integer conversions and conditional negate with status flags.
// Assumes: Issue ports carry one operation per unit per cycle, guard bit 0 only.
// Notes: Status word holds the sticky flags and the rounding mode field.
// Behaviour
// - Float to integer truncates toward zero always.
// - Truncating convert: float unit, code 21, latency 3.
// - Denormal source converts as zero, sets flag.
// - Conversion exceptions set matching status flags.
// - Status flags sticky; only explicit write clears.
// - Flags update on the destination write edge.
// - Simultaneous flag updates OR with existing value.
// - Guard bit 0 gates destination and flags.
// - Flags-only convert returns vector, code 129.
// - Flags-only operations leave status flags alone.
// - Flags-only denormal evaluates zero, sets flag bit.
// - Flags-only and negate write only when guarded.
// - Negate: code 77, latency 2, zero passes.
// - Integer to float rounds by status mode.
// - Integer to float exceptions set status flags.
`include "fic_params.svh"

module fic_top #(
  parameter int DEST_W = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic falu_issue,
  input wire logic [`FIC_OPC_W-1:0] falu_opcode,
  input wire logic [31:0] falu_src1,
  input wire logic falu_guard,
  input wire logic [DEST_W-1:0] falu_dest,
  input wire logic dsp_issue,
  input wire logic [`FIC_OPC_W-1:0] dsp_opcode,
  input wire logic [31:0] dsp_src1,
  input wire logic [31:0] dsp_src2,
  input wire logic dsp_guard,
  input wire logic [DEST_W-1:0] dsp_dest,
  input wire logic status_write,
  input wire logic [31:0] status_write_data,
  input wire logic [31:0] other_flag_set,
  output logic falu_wr_en,
  output logic [DEST_W-1:0] falu_wr_index,
  output logic [31:0] falu_wr_data,
  output logic dsp_wr_en,
  output logic [DEST_W-1:0] dsp_wr_index,
  output logic [31:0] dsp_wr_data,
  output logic [31:0] status_word
);

  // ===================================================================
  // Float unit issue decode
  wire is_f2i = (falu_opcode == `FIC_OPC_F2I_TRUNC);
  wire is_f2i_flags = (falu_opcode == `FIC_OPC_F2I_TRUNC_FLAGS);
  wire is_i2f = (falu_opcode == `FIC_OPC_I2F);
  wire falu_take = falu_issue & (is_f2i | is_f2i_flags | is_i2f);
  wire fic_pkg::fic_op_t next_s1_op = is_f2i ? fic_pkg::FIC_OP_F2I :
                                      is_f2i_flags ? fic_pkg::FIC_OP_F2I_FLAGS :
                                      fic_pkg::FIC_OP_I2F;

  logic s1_valid;
  logic s1_guard;
  fic_pkg::fic_op_t s1_op;
  logic [DEST_W-1:0] s1_dest;
  logic [31:0] s1_src;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_valid <= 1'b0;
      s1_guard <= 1'b0;
      s1_op <= fic_pkg::FIC_OP_F2I;
      s1_dest <= '0;
      s1_src <= 32'h0;
    end else begin
      s1_valid <= falu_take;
      s1_guard <= falu_guard;
      s1_op <= next_s1_op;
      s1_dest <= falu_dest;
      s1_src <= falu_src1;
    end
  end

  // ===================================================================
  // Truncating float to integer, evaluated in stage one
  wire f_sign = s1_src[31];
  wire [7:0] f_exp = s1_src[30:23];
  wire [22:0] f_man = s1_src[22:0];
  wire man_nz = |f_man;
  wire exp_special = (f_exp == `FIC_EXP_SPECIAL);
  wire exp_zero = (f_exp == 8'h0);
  wire below_one = (f_exp < `FIC_EXP_BIAS);
  wire too_big = (f_exp >= `FIC_EXP_SAT);
  // Exactly the most negative integer is representable and raises nothing.
  wire exact_min = f_sign & (f_exp == `FIC_EXP_SAT) & ~man_nz;
  wire [7:0] unbiased = f_exp - `FIC_EXP_BIAS;
  wire [63:0] scaled = {40'h0, 1'b1, f_man} << unbiased[4:0];
  wire [31:0] mag = {1'b0, scaled[53:23]};
  wire frac_lost = |scaled[22:0];
  wire [31:0] sat_val = f_sign ? `FIC_INT_MIN : `FIC_INT_MAX;

  // Fraction bits are dropped, never rounded, so the mode field is not read.
  wire [31:0] f2i_val = exp_special ? (man_nz ? 32'h0 : sat_val) :
                        (exp_zero | below_one) ? 32'h0 :
                        too_big ? sat_val :
                        (f_sign ? -mag : mag);
  wire flag_bad = exp_special | (too_big & ~exp_special & ~exact_min);
  wire flag_inexact = ~exp_special & ~exp_zero & ~too_big & (below_one | frac_lost);
  wire flag_denorm = exp_zero & man_nz;

  logic [31:0] f2i_flags;
  always_comb begin
    f2i_flags = 32'h0;
    f2i_flags[`FIC_INEXACT_BIT] = flag_inexact;
    f2i_flags[`FIC_BAD_OPERAND_BIT] = flag_bad;
    f2i_flags[`FIC_DENORM_ZEROED_BIT] = flag_denorm;
  end

  // ===================================================================
  // Integer to float converter
  fic_cvt_if cvt ();
  assign cvt.operand = falu_src1;
  assign cvt.rmode = status_word[`FIC_RMODE_MSB:`FIC_RMODE_LSB];

  fic_int_to_float u_i2f (
    .ref_clk(ref_clk),
    .rst(rst),
    .cvt(cvt.converter)
  );

  // ===================================================================
  // Stage two
  logic s2_valid;
  logic s2_guard;
  fic_pkg::fic_op_t s2_op;
  logic [DEST_W-1:0] s2_dest;
  logic [31:0] s2_val;
  logic [31:0] s2_flags;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s2_valid <= 1'b0;
      s2_guard <= 1'b0;
      s2_op <= fic_pkg::FIC_OP_F2I;
      s2_dest <= '0;
      s2_val <= 32'h0;
      s2_flags <= 32'h0;
    end else begin
      s2_valid <= s1_valid;
      s2_guard <= s1_guard;
      s2_op <= s1_op;
      s2_dest <= s1_dest;
      s2_val <= f2i_val;
      s2_flags <= f2i_flags;
    end
  end

  // ===================================================================
  // Stage three: destination write and flag merge
  wire s2_is_i2f = (s2_op == fic_pkg::FIC_OP_I2F);
  wire s2_is_flags_only = (s2_op == fic_pkg::FIC_OP_F2I_FLAGS);
  wire s2_fire = s2_valid & s2_guard;
  wire [31:0] op_flags = s2_is_i2f ? cvt.flags : s2_flags;
  wire [31:0] next_falu_data = s2_is_i2f ? cvt.result :
                               s2_is_flags_only ? s2_flags : s2_val;
  // Flags-only results never reach the status word.
  wire [31:0] falu_set = (s2_fire & ~s2_is_flags_only) ? op_flags : 32'h0;
  wire [31:0] hw_set = (falu_set | other_flag_set) & `FIC_FLAG_MASK;
  // A hardware set in the same cycle as an explicit write survives it.
  wire [31:0] next_status = (status_write ? status_write_data : status_word) |
                            hw_set;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      falu_wr_en <= 1'b0;
      falu_wr_index <= '0;
      falu_wr_data <= 32'h0;
      status_word <= `FIC_STATUS_RESET;
    end else begin
      falu_wr_en <= s2_fire;
      falu_wr_index <= s2_dest;
      falu_wr_data <= next_falu_data;
      status_word <= next_status;
    end
  end

  // ===================================================================
  // DSP unit: conditional negate
  logic d1_valid;
  logic d1_guard;
  logic [DEST_W-1:0] d1_dest;
  logic [31:0] d1_src1;
  logic [31:0] d1_src2;
  wire dsp_take = dsp_issue & (dsp_opcode == `FIC_OPC_COND_NEGATE);
  wire [31:0] next_dsp_data = (d1_src1 == 32'h0) ? d1_src2 : -d1_src2;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      d1_valid <= 1'b0;
      d1_guard <= 1'b0;
      d1_dest <= '0;
      d1_src1 <= 32'h0;
      d1_src2 <= 32'h0;
    end else begin
      d1_valid <= dsp_take;
      d1_guard <= dsp_guard;
      d1_dest <= dsp_dest;
      d1_src1 <= dsp_src1;
      d1_src2 <= dsp_src2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dsp_wr_en <= 1'b0;
      dsp_wr_index <= '0;
      dsp_wr_data <= 32'h0;
    end else begin
      dsp_wr_en <= d1_valid & d1_guard;
      dsp_wr_index <= d1_dest;
      dsp_wr_data <= next_dsp_data;
    end
  end

endmodule

// [bench/fic_properties.sv]
// Purpose: Concurrent checks on the conversion and negate datapath ports.
// Assumes: One clock domain; flags and rounding mode as laid out in fic_params.svh.
// Notes: Attached by bind from the testbench file.
`include "fic_params.svh"

module fic_props #(
  parameter int DEST_W = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic falu_issue,
  input wire logic [`FIC_OPC_W-1:0] falu_opcode,
  input wire logic [31:0] falu_src1,
  input wire logic falu_guard,
  input wire logic dsp_issue,
  input wire logic [`FIC_OPC_W-1:0] dsp_opcode,
  input wire logic [31:0] dsp_src1,
  input wire logic [31:0] dsp_src2,
  input wire logic dsp_guard,
  input wire logic [DEST_W-1:0] dsp_dest,
  input wire logic status_write,
  input wire logic [31:0] status_write_data,
  input wire logic [31:0] other_flag_set,
  input wire logic falu_wr_en,
  input wire logic [31:0] falu_wr_data,
  input wire logic dsp_wr_en,
  input wire logic [DEST_W-1:0] dsp_wr_index,
  input wire logic [31:0] dsp_wr_data,
  input wire logic [31:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] M = `FIC_FLAG_MASK;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // =====================================================================
  // Issue sequences
  sequence s_ftake;
    falu_issue && falu_guard && falu_opcode inside {`FIC_OPC_F2I_TRUNC,
      `FIC_OPC_F2I_TRUNC_FLAGS, `FIC_OPC_I2F};
  endsequence
  sequence s_dtake;
    dsp_issue && dsp_guard && dsp_opcode == `FIC_OPC_COND_NEGATE;
  endsequence

  // =====================================================================
  // Properties
  a_falu_latency: assert property (s_ftake |-> ##3 falu_wr_en)
    else $error("float unit write missing three cycles after issue");
  a_dsp_latency: assert property (s_dtake |-> ##2 dsp_wr_en &&
    dsp_wr_index == $past(dsp_dest, 2))
    else $error("negate write missing or misdirected");
  a_negate_value: assert property (s_dtake |-> ##2 dsp_wr_data ==
    (($past(dsp_src1, 2) == 32'h0) ? $past(dsp_src2, 2) : -$past(dsp_src2, 2)))
    else $error("negate result wrong");
  a_flags_sticky: assert property (!status_write |=>
    ((status_word ^ $past(status_word)) & ~(status_word & M)) == 32'h0)
    else $error("status word changed other than by setting a flag");
  a_write_loads: assert property (status_write |=> (status_word | M) ==
    ($past(status_write_data) | M) && ($past(status_write_data) & M & ~status_word) == 32'h0)
    else $error("status write not loaded");
  a_other_merged: assert property ((other_flag_set & M) != 32'h0 |=>
    ($past(other_flag_set) & M & ~status_word) == 32'h0)
    else $error("simultaneous flag set lost");
  a_flag_with_write: assert property (!$past(status_write) &&
    ($past(other_flag_set) & M) == 32'h0 && (status_word & ~$past(status_word) & M) != 32'h0
    |-> falu_wr_en)
    else $error("flag set without a destination write");
  a_nan_zero: assert property (falu_issue && falu_guard &&
    falu_opcode == `FIC_OPC_F2I_TRUNC && falu_src1[30:23] == 8'hff && falu_src1[22:0] != 23'h0
    |-> ##3 falu_wr_data == 32'h0 && status_word[`FIC_BAD_OPERAND_BIT])
    else $error("not-a-number conversion wrong");
endmodule

// [bench/fic_regfile_model.sv]
// Purpose: Register file on the far side of both write ports.
// Assumes: Writes land on the edge after the write strobe is seen.
// Notes: Entries start at a known pattern so an unwanted write shows.
module fic_regfile_model #(
  parameter int DEST_W = 7
) (
  input wire logic ref_clk,
  input wire logic falu_wr_en,
  input wire logic [DEST_W-1:0] falu_wr_index,
  input wire logic [31:0] falu_wr_data,
  input wire logic dsp_wr_en,
  input wire logic [DEST_W-1:0] dsp_wr_index,
  input wire logic [31:0] dsp_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rf [2**DEST_W];

  initial begin
    for (int i = 0; i < 2**DEST_W; i++) begin
      rf[i] = 32'h5a5a_0000 + i;
    end
  end

  always @(posedge ref_clk) begin
    if (falu_wr_en) begin
      rf[falu_wr_index] <= falu_wr_data;
    end
    if (dsp_wr_en) begin
      rf[dsp_wr_index] <= dsp_wr_data;
    end
  end
endmodule

// [bench/testbench.sv]
// Purpose: Directed checks of the conversions, negate and status word.
// Assumes: Inputs change at the falling edge; results read from the register model.
// Notes: Each scenario waits a fixed four cycles, enough for both unit latencies.
`include "fic_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEST_W = 7;
  logic ref_clk = 0, rst = 1, falu_issue = 0, falu_guard = 0, dsp_issue = 0, dsp_guard = 0;
  logic status_write = 0, falu_wr_en, dsp_wr_en;
  logic [7:0] falu_opcode = 0, dsp_opcode = 0;
  logic [DEST_W-1:0] falu_dest = 0, dsp_dest = 0, falu_wr_index, dsp_wr_index;
  logic [31:0] falu_src1 = 0, dsp_src1 = 0, dsp_src2 = 0, status_write_data = 0;
  logic [31:0] other_flag_set = 0, falu_wr_data, dsp_wr_data, status_word;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  logic [31:0] fs [8] = '{32'h4040_0000, 32'h4024_7ae1, 32'hff4f_ffff, 32'h7f80_0000,
    32'hbfc1_47ae, 32'h0040_0000, 32'hffff_ffff, 32'hffbf_ffff};
  logic [31:0] fr [8] = '{32'h3, 32'h2, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff, 32'h0,
    32'h0, 32'h0};
  logic [31:0] fv [8] = '{32'h0, 32'h2, 32'h10, 32'h10, 32'h2, 32'h20, 32'h10, 32'h10};
  logic [31:0] is [6] = '{32'h3, 32'hffff_ffff, 32'hffff_fffd, 32'h7fff_ffff, 32'h8000_0000,
    32'h7fff_fff1};
  logic [31:0] ir [6] = '{32'h4040_0000, 32'hbf80_0000, 32'hc040_0000, 32'h4f00_0000,
    32'hcf00_0000, 32'h4f00_0000};
  logic [31:0] ix [6] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h2};
  logic [31:0] na [4] = '{32'h0, 32'hffff_0000, 32'h0, 32'h1};
  logic [31:0] nb [4] = '{32'h1, 32'habc, 32'hffff_ff9c, 32'hffff_ffff};
  logic [31:0] nr [4] = '{32'h1, 32'hffff_f544, 32'hffff_ff9c, 32'h1};
  // Operands whose result in the directed rounding mode used differs from the round-to-nearest result.
  logic [31:0] mi [3] = '{32'h7fff_ffff, 32'h7fff_ff01, 32'h8000_00ff};
  logic [31:0] mr [3] = '{32'h4eff_ffff, 32'h4eff_ffff, 32'hceff_ffff};

  fic_top #(.DEST_W(DEST_W)) uut (.*);
  fic_regfile_model #(.DEST_W(DEST_W)) regs (.*);

  initial forever #4 ref_clk = ~ref_clk;

  // Far-too-long runs mean a hang; the whole sequence needs well under a thousand cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  // =====================================================================
  // Drivers and compare
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic sw(input logic [31:0] v);
    @(negedge ref_clk);
    status_write = 1;
    status_write_data = v;
    @(negedge ref_clk);
    status_write = 0;
  endtask
  task automatic fop(input logic [7:0] op, input logic [31:0] a, input logic g, input int d);
    @(negedge ref_clk);
    falu_issue = 1;
    falu_opcode = op;
    falu_src1 = a;
    falu_guard = g;
    falu_dest = DEST_W'(d);
  endtask
  task automatic dop(input logic [31:0] a, input logic [31:0] b, input logic g, input int d);
    @(negedge ref_clk);
    dsp_issue = 1;
    dsp_opcode = `FIC_OPC_COND_NEGATE;
    dsp_src1 = a;
    dsp_src2 = b;
    dsp_guard = g;
    dsp_dest = DEST_W'(d);
  endtask
  task automatic fin();
    @(negedge ref_clk);
    falu_issue = 0;
    dsp_issue = 0;
    repeat (4) @(negedge ref_clk);
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_trunc();
    for (int i = 0; i < 8; i++) begin
      sw(32'h200);
      fop(`FIC_OPC_F2I_TRUNC, fs[i], 1'h1, i);
      fin();
      chk("trunc data", fr[i], regs.rf[i]);
      chk("trunc status", fv[i] | 32'h200, status_word);
      fop(`FIC_OPC_F2I_TRUNC_FLAGS, fs[i], 1'h1, i + 16);
      fin();
      chk("flag vector", fv[i], regs.rf[i + 16]);
      chk("status kept", fv[i] | 32'h200, status_word);
    end
    $display("trunc test done");
  endtask
  task automatic t_guard();
    sw(32'h0);
    fop(`FIC_OPC_F2I_TRUNC, 32'hff4f_ffff, 1'h0, 40);
    fop(`FIC_OPC_F2I_TRUNC_FLAGS, 32'hff4f_ffff, 1'h0, 41);
    dop(32'h1, 32'h5, 1'h0, 42);
    fin();
    for (int i = 40; i < 43; i++) begin
      chk("guarded dest", 32'h5a5a_0000 + i, regs.rf[i]);
    end
    chk("guarded status", 32'h0, status_word);
    $display("guard test done");
  endtask
  task automatic t_negate();
    for (int i = 0; i < 4; i++) begin
      dop(na[i], nb[i], 1'h1, 50 + i);
    end
    fin();
    for (int i = 0; i < 4; i++) begin
      chk("negate data", nr[i], regs.rf[50 + i]);
    end
    $display("negate test done");
  endtask
  task automatic t_i2f();
    for (int i = 0; i < 6; i++) begin
      sw(32'h0);
      fop(`FIC_OPC_I2F, is[i], 1'h1, 60 + i);
      fin();
      chk("float data", ir[i], regs.rf[60 + i]);
      chk("float status", ix[i], status_word);
    end
    // Modes 1, 2 and 3: toward zero, toward plus and toward minus infinity.
    for (int m = 1; m < 4; m++) begin
      sw({22'h0, 2'(m), 8'h0});
      fop(`FIC_OPC_I2F, mi[m - 1], 1'h1, 69 + m);
      fin();
      chk("float mode data", mr[m - 1], regs.rf[69 + m]);
      chk("float mode status", {22'h0, 2'(m), 8'h2}, status_word);
    end
    $display("float test done");
  endtask
  task automatic t_sticky();
    sw(32'h34);
    fop(`FIC_OPC_F2I_TRUNC, 32'h4040_0000, 1'h1, 80);
    fin();
    chk("sticky", 32'h34, status_word);
    fop(`FIC_OPC_F2I_TRUNC, 32'h4024_7ae1, 1'h1, 81);
    @(negedge ref_clk);
    falu_issue = 0;
    @(negedge ref_clk);
    // Lands on the completing edge; bit 6 lies outside the flag field and must drop.
    other_flag_set = 32'h48;
    @(negedge ref_clk);
    chk("merged flags", 32'h3e, status_word);
    chk("write pulse", 32'h1, {31'h0, falu_wr_en});
    status_write = 1;
    status_write_data = 32'h0;
    other_flag_set = 32'h8;
    @(negedge ref_clk);
    status_write = 0;
    other_flag_set = 32'h0;
    chk("set over clear", 32'h8, status_word);
    $display("sticky test done");
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 0;
    t_trunc();
    t_guard();
    t_negate();
    t_i2f();
    t_sticky();
    complete_run();
  end
endmodule

bind fic_top fic_props #(.DEST_W(DEST_W)) u_props (.*);
